// ==== shared/qsh_map.vh ====
// qsh_map.vh: constants of the quad serial host slave port
// assumes: included by the port and its bench, nothing else
`ifndef QSH_MAP_VH
`define QSH_MAP_VH

// lane width codes
`define QSH_W_SINGLE     2'h0
`define QSH_W_DUAL       2'h1
`define QSH_W_QUAD       2'h2
`define QSH_W_RSVD       2'h3
`define QSH_W_RESET      2'h0

// transaction kinds, top two bits of the first byte
`define QSH_K_READ       2'h0
`define QSH_K_CMD        2'h1
`define QSH_K_WRITE      2'h2

// host command codes
`define QSH_C_ACTIVE     6'h00
`define QSH_C_STANDBY    6'h01
`define QSH_C_SLEEP      6'h02
`define QSH_C_PDOWN_A    6'h03
`define QSH_C_PDOWN_B    6'h10
`define QSH_C_RSTPULSE   6'h28

// local register addresses and address constants in the 22 bit space
`define QSH_A_WIDTH      22'h3FFFFC
`define QSH_A_STATUS     22'h3FFFF8
`define QSH_A_ZERO       22'h000000
`define QSH_ADDR_ONE     22'h000001

// framing
`define QSH_BYTE_BITS    4'h8
`define QSH_HDR_LAST     3'h2
`define QSH_DATA_FIRST   3'h4
`define QSH_BYTE_SAT     3'h7

// power states, one-hot
`define QSH_P_ACTIVE     4'h1
`define QSH_P_STANDBY    4'h2
`define QSH_P_SLEEP      4'h4
`define QSH_P_PDOWN      4'h8

`endif

// ==== src/qsh_fifo.v ====
// qsh_fifo.v: small synchronous fifo for posted memory writes
// assumes: one clock, synchronous active low reset
`timescale 1ns/1ps
module qsh_fifo #(
  parameter WIDTH = 30,
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  input  wire             clk_i,
  input  wire             rst_n_i,
  input  wire             in_valid_i,
  output wire             in_ready_o,
  input  wire [WIDTH-1:0] in_data_i,
  output wire             out_valid_o,
  input  wire             out_ready_i,
  output reg  [WIDTH-1:0] out_data_o
);
  reg [WIDTH-1:0] mem_reg [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr_reg;
  reg [AW-1:0]    rd_ptr_reg;
  reg [AW:0]      count_reg;
  wire            push;
  wire            pop;
  wire [AW-1:0]   rd_ptr_next;
  wire            head_bypass;

  // full and empty come straight from the word count
  assign in_ready_o  = (count_reg != DEPTH[AW:0]);
  assign out_valid_o = (count_reg != {(AW+1){1'b0}});
  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_valid_o & out_ready_i;

  // storage holds no reset, pointers and count do
  always @(posedge clk_i) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= in_data_i;
    end
  end

  // pointer wrap assumes a power of two depth
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      wr_ptr_reg <= {AW{1'b0}};
      rd_ptr_reg <= {AW{1'b0}};
      count_reg  <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
      if (push & ~pop) begin
        count_reg <= count_reg + 1'b1;
      end else if (pop & ~push) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end

  // slot that sits at the head once this edge has passed
  assign rd_ptr_next = pop ? (rd_ptr_reg + 1'b1) : rd_ptr_reg;
  assign head_bypass = push & (wr_ptr_reg == rd_ptr_next);

  // head word through a register; a word written into the head slot
  // bypasses the array so it shows together with out_valid_o
  always @(posedge clk_i) begin
    if (head_bypass) begin
      out_data_o <= in_data_i;
    end else begin
      out_data_o <= mem_reg[rd_ptr_next];
    end
  end
endmodule // qsh_fifo

// ==== src/qsh_port.v ====
// qsh_port.v: host serial slave port, single/dual/quad lanes, mode 0
// assumes: serial pins arrive asynchronous and are synchronised here;
// memory behind it answers rd_req_o with rd_ack_i within a few cycles
//
// Overview of operation
// - mode 0 only, serial clock up to 30 MHz
// - single lane after reset, in/out split
// - width field: 00 single, 01 dual, 10 quad
// - multi-lane transaction starts with lines input
// - write finishes only when chip select rises
// - multi-lane: no drive until first read data byte
// - chip select high releases all data lines
// - lane order: three, two, miso, mosi
// - 4 MB space, msb first, select framed
// - unlimited bytes at consecutive addresses
// - read: 00, address, dummy, then data
// - write: 1 0, address, then data
// - command: 01 code, parameter, zero byte
// - commands only in single mode, except reset
// - power-off clears command settings
// - code 40h or two zero reads wake
// - code 41h standby, oscillator and pll on
// - code 42h sleep, clocks, pll and oscillator stopped, core power kept
// - codes 43h/50h power off, port alive
// - code 68h pulses core reset only
`timescale 1ns/1ps
`include "qsh_map.vh"
module qsh_port #(
  parameter FIFO_DEPTH = 8,
  parameter FIFO_AW    = 3
) (
  input  wire        clk_i,
  input  wire        rst_n_i,
  input  wire        sck_i,
  input  wire        cs_n_i,
  input  wire [3:0]  dq_i,
  output wire [3:0]  dq_o,
  output wire [3:0]  dq_oe_o,
  output wire        wr_valid_o,
  input  wire        wr_ready_i,
  output wire [21:0] wr_addr_o,
  output wire [7:0]  wr_data_o,
  output reg         wr_overrun_o,
  output reg         rd_req_o,
  output reg  [21:0] rd_addr_o,
  input  wire        rd_ack_i,
  input  wire [7:0]  rd_data_i,
  output wire [1:0]  lane_width_o,
  output wire        core_clk_en_o,
  output wire        pll_on_o,
  output wire        osc_on_o,
  output wire        core_pwr_on_o,
  output reg         core_rst_o,
  output reg         cfg_clear_o
);
  // synchronisers and edge history
  reg        sck_s1_reg;
  reg        sck_s2_reg;
  reg        sck_s3_reg;
  reg        cs_s1_reg;
  reg        cs_s2_reg;
  reg        cs_s3_reg;
  reg [3:0]  dq_s1_reg;
  reg [3:0]  dq_s2_reg;
  // transaction state
  reg [1:0]  width_reg;
  reg [1:0]  width_pend_reg;
  reg        width_wr_reg;
  reg [3:0]  bit_cnt_reg;
  reg [2:0]  byte_cnt_reg;
  reg [7:0]  rx_reg;
  reg [1:0]  kind_reg;
  reg [21:0] addr_reg;
  reg [5:0]  cmd_reg;
  reg [7:0]  param_reg;
  reg [7:0]  tx_reg;
  reg [7:0]  rd_buf_reg;
  reg [3:0]  out_reg;
  reg [3:0]  oe_reg;
  reg [3:0]  pstate_reg;
  reg        zero_seen_reg;

  wire       sck_rise;
  wire       sck_fall;
  wire       cs_rise;
  wire       cs_fall;
  reg  [3:0] step;
  reg  [7:0] rx_next;
  wire [3:0] bit_sum;
  wire       byte_done;
  wire       hdr_end;
  wire       data_byte;
  wire       pf_fire;
  wire [21:0] pf_addr;
  wire       pf_local;
  reg  [7:0] local_val;
  wire       wr_byte;
  wire       wr_local;
  wire       push_valid;
  wire       push_ready;
  wire       cmd_exec;
  wire       multi;

  // two flops on every pin before use
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      sck_s1_reg <= 1'b0;
      sck_s2_reg <= 1'b0;
      sck_s3_reg <= 1'b0;
      cs_s1_reg  <= 1'b1;
      cs_s2_reg  <= 1'b1;
      cs_s3_reg  <= 1'b1;
      dq_s1_reg  <= 4'h0;
      dq_s2_reg  <= 4'h0;
    end else begin
      sck_s1_reg <= sck_i;
      sck_s2_reg <= sck_s1_reg;
      sck_s3_reg <= sck_s2_reg;
      cs_s1_reg  <= cs_n_i;
      cs_s2_reg  <= cs_s1_reg;
      cs_s3_reg  <= cs_s2_reg;
      dq_s1_reg  <= dq_i;
      dq_s2_reg  <= dq_s1_reg;
    end
  end

  // edges of the sampled serial clock and select
  assign sck_rise = sck_s2_reg & ~sck_s3_reg & ~cs_s2_reg;
  assign sck_fall = ~sck_s2_reg & sck_s3_reg & ~cs_s2_reg;
  assign cs_rise  = cs_s2_reg & ~cs_s3_reg;
  assign cs_fall  = ~cs_s2_reg & cs_s3_reg;
  assign multi    = (width_reg != `QSH_W_SINGLE);

  // lanes per edge and msb-first assembly of the incoming byte
  always @* begin
    case (width_reg)
      `QSH_W_DUAL: begin
        step    = 4'h2;
        rx_next = {rx_reg[5:0], dq_s2_reg[1:0]};
      end
      `QSH_W_QUAD: begin
        step    = 4'h4;
        rx_next = {rx_reg[3:0], dq_s2_reg};
      end
      default: begin
        step    = 4'h1;
        rx_next = {rx_reg[6:0], dq_s2_reg[0]};
      end
    endcase
  end

  assign bit_sum   = bit_cnt_reg + step;
  assign byte_done = sck_rise & (bit_sum == `QSH_BYTE_BITS);
  assign hdr_end   = byte_done & (byte_cnt_reg == `QSH_HDR_LAST);
  assign data_byte = byte_done & (byte_cnt_reg > `QSH_HDR_LAST);

  // read prefetch: address at header end, then one per data byte
  assign pf_fire  = (hdr_end | data_byte) & (kind_reg == `QSH_K_READ);
  assign pf_addr  = hdr_end ? {addr_reg[21:8], rx_next} : addr_reg;
  assign pf_local = (pf_addr == `QSH_A_WIDTH) |
                    (pf_addr == `QSH_A_STATUS);

  // local registers read back through the same read path
  always @* begin
    if (pf_addr == `QSH_A_WIDTH) begin
      local_val = {6'h00, width_reg};
    end else begin
      local_val = {4'h0, pstate_reg};
    end
  end

  // write data bytes: width and status registers are local and never posted, the rest is posted
  assign wr_byte    = data_byte & (kind_reg == `QSH_K_WRITE);
  assign wr_local   = (addr_reg == `QSH_A_WIDTH) |
                      (addr_reg == `QSH_A_STATUS);
  assign push_valid = wr_byte & ~wr_local;

  // a command runs at the end of its third byte
  assign cmd_exec = byte_done & (kind_reg == `QSH_K_CMD) &
                    (byte_cnt_reg == `QSH_HDR_LAST) &
                    (~multi | (cmd_reg == `QSH_C_RSTPULSE));

  // framing, shift registers and address stepping
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      bit_cnt_reg  <= 4'h0;
      byte_cnt_reg <= 3'h0;
      rx_reg       <= 8'h00;
      kind_reg     <= `QSH_K_READ;
      addr_reg     <= 22'h000000;
      cmd_reg      <= 6'h00;
      param_reg    <= 8'h00;
    end else if (cs_s2_reg) begin
      bit_cnt_reg  <= 4'h0;
      byte_cnt_reg <= 3'h0;
    end else if (sck_rise) begin
      rx_reg <= rx_next;
      if (byte_done) begin
        bit_cnt_reg <= 4'h0;
        if (byte_cnt_reg != `QSH_BYTE_SAT) begin
          byte_cnt_reg <= byte_cnt_reg + 3'h1;
        end
        case (byte_cnt_reg)
          3'h0: begin
            kind_reg        <= rx_next[7:6];
            addr_reg[21:16] <= rx_next[5:0];
            cmd_reg         <= rx_next[5:0];
          end
          3'h1: begin
            addr_reg[15:8] <= rx_next;
            param_reg      <= rx_next;
          end
          3'h2: begin
            if (kind_reg == `QSH_K_READ) begin
              addr_reg <= pf_addr + `QSH_ADDR_ONE;
            end else begin
              addr_reg[7:0] <= rx_next;
            end
          end
          default: begin
            addr_reg <= addr_reg + `QSH_ADDR_ONE;
          end
        endcase
      end else begin
        bit_cnt_reg <= bit_sum;
      end
    end
  end

  // read data: buffer, then load at byte boundary, shift on falls
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      rd_buf_reg <= 8'h00;
      rd_req_o   <= 1'b0;
      rd_addr_o  <= 22'h000000;
      tx_reg     <= 8'h00;
      out_reg    <= 4'h0;
    end else begin
      rd_req_o <= pf_fire & ~pf_local;
      if (pf_fire) begin
        rd_addr_o <= pf_addr;
      end
      if (pf_fire & pf_local) begin
        rd_buf_reg <= local_val;
      end else if (rd_ack_i) begin
        rd_buf_reg <= rd_data_i;
      end
      if (data_byte & (kind_reg == `QSH_K_READ)) begin
        tx_reg <= rd_buf_reg;
      end else if (sck_fall) begin
        case (width_reg)
          `QSH_W_DUAL: begin
            out_reg <= {2'h0, tx_reg[7:6]};
            tx_reg  <= {tx_reg[5:0], 2'h0};
          end
          `QSH_W_QUAD: begin
            out_reg <= tx_reg[7:4];
            tx_reg  <= {tx_reg[3:0], 4'h0};
          end
          default: begin
            out_reg <= {2'h0, tx_reg[7], 1'b0};
            tx_reg  <= {tx_reg[6:0], 1'b0};
          end
        endcase
      end
    end
  end

  // pin direction: inputs at frame end; single drives miso from frame start, multi from data
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      oe_reg <= 4'h0;
    end else if (cs_rise | cs_s2_reg) begin
      oe_reg <= 4'h0;
    end else if (cs_fall) begin
      oe_reg <= multi ? 4'h0 : 4'h2;
    end else if (sck_fall & multi & (kind_reg == `QSH_K_READ) &
                 (byte_cnt_reg >= `QSH_DATA_FIRST)) begin
      oe_reg <= (width_reg == `QSH_W_QUAD) ? 4'hF : 4'h3;
    end
  end

  assign dq_o    = out_reg;
  assign dq_oe_o = oe_reg;

  // lane width: captured during a write, applied when select rises
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      width_reg      <= `QSH_W_RESET;
      width_pend_reg <= `QSH_W_RESET;
      width_wr_reg   <= 1'b0;
    end else if (cs_rise) begin
      if (width_wr_reg) begin
        width_reg <= width_pend_reg;
      end
      width_wr_reg <= 1'b0;
    end else if (wr_byte & (addr_reg == `QSH_A_WIDTH) &
                 (rx_next[1:0] != `QSH_W_RSVD)) begin
      width_pend_reg <= rx_next[1:0];
      width_wr_reg   <= 1'b1;
    end
  end

  assign lane_width_o = width_reg;

  // posted writes wait here; a full queue drops and flags the byte
  qsh_fifo #(
    .WIDTH (30),
    .DEPTH (FIFO_DEPTH),
    .AW    (FIFO_AW)
  ) u_wr_fifo (
    .clk_i       (clk_i),
    .rst_n_i     (rst_n_i),
    .in_valid_i  (push_valid),
    .in_ready_o  (push_ready),
    .in_data_i   ({addr_reg, rx_next}),
    .out_valid_o (wr_valid_o),
    .out_ready_i (wr_ready_i),
    .out_data_o  ({wr_addr_o, wr_data_o})
  );

  // overrun flag: cleared at frame start, a new loss wins the clear
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      wr_overrun_o <= 1'b0;
    end else if (push_valid & ~push_ready) begin
      wr_overrun_o <= 1'b1;
    end else if (cs_fall) begin
      wr_overrun_o <= 1'b0;
    end
  end

  // power state machine driven by commands and zero-address reads
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      pstate_reg    <= `QSH_P_ACTIVE;
      zero_seen_reg <= 1'b0;
      core_rst_o    <= 1'b0;
      cfg_clear_o   <= 1'b0;
    end else begin
      core_rst_o  <= 1'b0;
      cfg_clear_o <= 1'b0;
      if (hdr_end & (kind_reg == `QSH_K_READ)) begin
        if (pf_addr == `QSH_A_ZERO) begin
          zero_seen_reg <= ~zero_seen_reg;
          if (zero_seen_reg) begin
            pstate_reg <= `QSH_P_ACTIVE;
          end
        end else begin
          zero_seen_reg <= 1'b0;
        end
      end else if (hdr_end) begin
        zero_seen_reg <= 1'b0;
      end
      if (cmd_exec) begin
        case (cmd_reg)
          `QSH_C_ACTIVE: begin
            pstate_reg <= `QSH_P_ACTIVE;
          end
          `QSH_C_STANDBY: begin
            pstate_reg <= `QSH_P_STANDBY;
          end
          `QSH_C_SLEEP: begin
            pstate_reg <= `QSH_P_SLEEP;
          end
          `QSH_C_PDOWN_A, `QSH_C_PDOWN_B: begin
            pstate_reg  <= `QSH_P_PDOWN;
            cfg_clear_o <= 1'b1;
          end
          `QSH_C_RSTPULSE: begin
            core_rst_o <= 1'b1;
          end
          default: begin
            core_rst_o <= 1'b0;
          end
        endcase
      end
    end
  end

  // power rails and clocks follow the state
  assign core_clk_en_o = pstate_reg[0];
  assign pll_on_o      = pstate_reg[0] | pstate_reg[1];
  assign osc_on_o      = pstate_reg[0] | pstate_reg[1];
  assign core_pwr_on_o = ~pstate_reg[3];
endmodule // qsh_port

// ==== bench/qsh_host.sv ====
// qsh_host.sv: host serial master model, mode 0
// assumes: clk_i is the device clock; data lines have pull-ups
`timescale 1ns/1ps
module qsh_host (
  input  wire        clk_i,
  input  wire  [3:0] dq_i,
  output logic       sck_o,
  output logic       cs_n_o,
  output logic [3:0] hd_o,
  output logic [3:0] hoe_o
);
  // serial clock idles low, no frame open
  initial begin
    sck_o = 1'b0;
    cs_n_o = 1'b1;
    hd_o = 4'hF;
    hoe_o = 4'h0;
  end
  // half a serial period: 4 device clocks, 800 ns period in all modes
  task automatic half();
    repeat (4) @(posedge clk_i);
    #1;
  endtask
  task automatic open_frame();
    cs_n_o = 1'b0;
    half();
  endtask
  // lines are let go with the select so the pull-ups take over
  task automatic close_frame();
    half();
    cs_n_o = 1'b1;
    hoe_o = 4'h0;
    half();
    half();
  endtask
  // one byte msb first, w lanes per edge; rx in multi mode frees lines
  task automatic xbyte(input logic [7:0] tx, input int w, input bit rx,
                       output logic [7:0] rd);
    logic [7:0] s;
    logic [3:0] m;
    s = tx;
    rd = 8'h00;
    m = 4'((1 << w) - 1);
    for (int i = 0; i < 8 / w; i++) begin
      hoe_o = (rx && w > 1) ? 4'h0 : m;
      hd_o = s[7:4] >> (4 - w);
      half();
      rd = (rd << w) | ((w == 1) ? {7'h0, dq_i[1]} : {4'h0, dq_i & m});
      sck_o = 1'b1;
      half();
      sck_o = 1'b0;
      s = s << w;
    end
  endtask
endmodule // qsh_host

// ==== bench/qsh_port_properties.sv ====
// qsh_port_properties.sv: port boundary checks of the serial slave
// assumes: bound into qsh_port, sees its ports only
`timescale 1ns/1ps
module qsh_port_properties #(
  parameter FIFO_DEPTH = 8,
  parameter FIFO_AW    = 3
) (
  input wire       clk_i,
  input wire       rst_n_i,
  input wire       cs_n_i,
  input wire [3:0] dq_oe_o,
  input wire       rd_req_o,
  input wire [1:0] lane_width_o,
  input wire       core_clk_en_o,
  input wire       pll_on_o,
  input wire       osc_on_o,
  input wire       core_pwr_on_o,
  input wire       core_rst_o,
  input wire       cfg_clear_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  reg req_seen_reg;
  // a memory fetch has been made inside the current frame
  always @(posedge clk_i) begin
    if (!rst_n_i || cs_n_i) req_seen_reg <= 1'b0;
    else if (rd_req_o) req_seen_reg <= 1'b1;
  end
  a_lines_released: assert property (cs_n_i [*5] |-> dq_oe_o == 4'h0)
    else $error("data lines driven after deselect");
  a_no_early_drive: assert property ($rose(|dq_oe_o) &&
    lane_width_o != 2'h0 |-> req_seen_reg) else $error("early drive");
  a_drive_pattern: assert property (!cs_n_i && dq_oe_o != 4'h0 |->
    dq_oe_o == (lane_width_o == 2'h0 ? 4'h2 :
    lane_width_o == 2'h1 ? 4'h3 : 4'hF)) else $error("wrong lanes");
  a_width_legal: assert property (lane_width_o != 2'h3)
    else $error("reserved width taken");
  a_width_at_end: assert property ($changed(lane_width_o) |-> cs_n_i)
    else $error("width changed inside a frame");
  a_fetch_pulse: assert property (rd_req_o |=> !rd_req_o)
    else $error("fetch request longer than one cycle");
  a_standby_keeps: assert property (!core_clk_en_o && pll_on_o |->
    osc_on_o && core_pwr_on_o) else $error("standby stopped too much");
  a_sleep_stops: assert property ($fell(pll_on_o) |->
    !osc_on_o && !core_clk_en_o) else $error("sleep left clocks on");
  a_cmd_single: assert property ($fell(core_clk_en_o) |->
    lane_width_o == 2'h0) else $error("command run in multi lane mode");
  a_pdown_clear: assert property (cfg_clear_o |->
    ##[0:2] !core_pwr_on_o) else $error("clear without power off");
  a_reset_pulse: assert property (core_rst_o |=> !core_rst_o)
    else $error("core reset longer than one cycle");
endmodule // qsh_port_properties
bind qsh_port qsh_port_properties #(.FIFO_DEPTH(FIFO_DEPTH),
  .FIFO_AW(FIFO_AW)) qsh_port_properties_inst (.clk_i(clk_i),
  .rst_n_i(rst_n_i), .cs_n_i(cs_n_i), .dq_oe_o(dq_oe_o),
  .rd_req_o(rd_req_o), .lane_width_o(lane_width_o),
  .core_clk_en_o(core_clk_en_o), .pll_on_o(pll_on_o), .osc_on_o(osc_on_o),
  .core_pwr_on_o(core_pwr_on_o), .core_rst_o(core_rst_o),
  .cfg_clear_o(cfg_clear_o));

// ==== bench/qsh_port_tb.sv ====
// qsh_port_tb.sv: self-checking bench of the serial slave port
// assumes: host model on the pins, bench answers the memory side
`timescale 1ns/1ps
`include "qsh_map.vh"
module qsh_port_tb;
  logic        clk_i, rst_n_i, wr_ready_i, rd_ack_i;
  logic [7:0]  rd_data_i, got;
  wire  [3:0]  dq_o, dq_oe_o, hd, hoe, dq_w;
  wire         sck, cs_n, wr_valid_o, wr_overrun_o, rd_req_o;
  wire  [21:0] wr_addr_o, rd_addr_o;
  wire  [7:0]  wr_data_o;
  wire  [1:0]  lane_width_o;
  wire         core_clk_en_o, pll_on_o, osc_on_o, core_pwr_on_o;
  wire         core_rst_o, cfg_clear_o;
  int          miscompares = 0, checks_done = 0, cyc = 0, lw = 1;
  int          rst_cnt = 0, clr_cnt = 0;
  logic [7:0]  codes [4] = '{8'h41, 8'h42, 8'h43, 8'h50};
  logic [3:0]  pw [4] = '{4'h7, 4'h1, 4'h0, 4'h0};
  logic [7:0]  st [4] = '{8'h02, 8'h04, 8'h08, 8'h08};
  // pad level: device drive, else host drive, else pull-up
  assign dq_w = (dq_oe_o & dq_o) | (~dq_oe_o & hoe & hd) | (~dq_oe_o & ~hoe);
  qsh_port qsh_port_inst (.clk_i(clk_i), .rst_n_i(rst_n_i), .sck_i(sck),
    .cs_n_i(cs_n), .dq_i(dq_w), .dq_o(dq_o), .dq_oe_o(dq_oe_o),
    .wr_valid_o(wr_valid_o), .wr_ready_i(wr_ready_i), .wr_addr_o(wr_addr_o),
    .wr_data_o(wr_data_o), .wr_overrun_o(wr_overrun_o), .rd_req_o(rd_req_o),
    .rd_addr_o(rd_addr_o), .rd_ack_i(rd_ack_i), .rd_data_i(rd_data_i),
    .lane_width_o(lane_width_o), .core_clk_en_o(core_clk_en_o),
    .pll_on_o(pll_on_o), .osc_on_o(osc_on_o), .core_pwr_on_o(core_pwr_on_o),
    .core_rst_o(core_rst_o), .cfg_clear_o(cfg_clear_o));
  qsh_host qsh_host_inst (.clk_i(clk_i), .dq_i(dq_w), .sck_o(sck),
    .cs_n_o(cs_n), .hd_o(hd), .hoe_o(hoe));
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  // memory answers a fetch in the same cycle; pulse counts; hang limit
  always @(posedge clk_i) begin
    #1;
    rd_ack_i = rd_req_o;
    rd_data_i = rd_addr_o[7:0] ^ 8'h5A;
    if (core_rst_o === 1'b1) rst_cnt++;
    if (cfg_clear_o === 1'b1) clr_cnt++;
    cyc++;
    if (cyc == 40000) begin
      miscompares++;
      give_verdict();
    end
  end
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] ex,
                     input logic [31:0] seen);
    checks_done++;
    if (seen !== ex) begin
      miscompares++;
      $display("BAD %s expected %0h seen %0h", nm, ex, seen);
    end
  endtask
  function automatic logic [3:0] pwr();
    return {core_clk_en_o, pll_on_o, osc_on_o, core_pwr_on_o};
  endfunction
  // opens a frame and sends the three header bytes
  task automatic hdr(input logic [1:0] k, input logic [21:0] a);
    qsh_host_inst.open_frame();
    qsh_host_inst.xbyte({k, a[21:16]}, lw, 1'b0, got);
    qsh_host_inst.xbyte(a[15:8], lw, 1'b0, got);
    qsh_host_inst.xbyte(a[7:0], lw, 1'b0, got);
  endtask
  task automatic cmd(input logic [7:0] c);
    hdr(c[7:6], {c[5:0], 16'h0000});
    qsh_host_inst.close_frame();
  endtask
  task automatic mwrite(input logic [21:0] a, input int n, input logic [7:0] d);
    hdr(`QSH_K_WRITE, a);
    for (int i = 0; i < n; i++) qsh_host_inst.xbyte(8'(d + i), lw, 1'b0, got);
    qsh_host_inst.close_frame();
  endtask
  // ev[8] set: local register value ev[7:0], else memory pattern
  task automatic mread(input logic [21:0] a, input int n, input logic [8:0] ev);
    hdr(`QSH_K_READ, a);
    qsh_host_inst.xbyte(8'h00, lw, 1'b1, got);
    for (int i = 0; i < n; i++) begin
      qsh_host_inst.xbyte(8'h00, lw, 1'b1, got);
      chk("rd_byte", ev[8] ? ev[7:0] : 8'(a + i) ^ 8'h5A, got);
    end
    qsh_host_inst.close_frame();
  endtask
  // consumer takes n posted words after having stalled
  task automatic drain(input logic [21:0] a, input int n, input logic [7:0] d);
    for (int i = 0; i < n; i++) begin
      chk("wr_valid", 1'b1, wr_valid_o);
      chk("wr_addr", 22'(a + i), wr_addr_o);
      chk("wr_data", 8'(d + i), wr_data_o);
      @(posedge clk_i);
      #1 wr_ready_i = 1'b1;
      @(posedge clk_i);
      #1 wr_ready_i = 1'b0;
    end
    chk("wr_valid", 1'b0, wr_valid_o);
  endtask
  // main sequence: single, then dual, then quad lanes
  initial begin
    rst_n_i = 1'b0;
    wr_ready_i = 1'b0;
    repeat (4) @(posedge clk_i);
    #1 rst_n_i = 1'b1;
    repeat (4) @(posedge clk_i);
    #1;
    chk("width", `QSH_W_RESET, lane_width_o);
    chk("oe", 4'h0, dq_oe_o);
    mwrite(22'h012340, 9, 8'h10);
    chk("overrun", 1'b1, wr_overrun_o);
    drain(22'h012340, 8, 8'h10);
    mread(22'h0001FE, 3, 9'h000);
    for (int i = 0; i < 4; i++) begin
      cmd(codes[i]);
      chk("power", pw[i], pwr());
      mread(`QSH_A_STATUS, 1, {1'b1, st[i]});
      mread(`QSH_A_ZERO, 0, 9'h000);
      mread(`QSH_A_ZERO, 0, 9'h000);
      chk("power", 4'hF, pwr());
    end
    chk("clears", 2, clr_cnt);
    cmd(8'h42);
    chk("power", 4'h1, pwr());
    cmd(8'h40);
    chk("power", 4'hF, pwr());
    cmd(8'h68);
    chk("rst_pulses", 1, rst_cnt);
    mwrite(`QSH_A_WIDTH, 1, {6'h00, `QSH_W_DUAL});
    lw = 2;
    chk("width", `QSH_W_DUAL, lane_width_o);
    cmd(8'h41);
    chk("power", 4'hF, pwr());
    cmd(8'h68);
    chk("rst_pulses", 2, rst_cnt);
    mread(22'h000200, 2, 9'h000);
    mwrite(22'h000300, 2, 8'hA5);
    drain(22'h000300, 2, 8'hA5);
    mwrite(`QSH_A_WIDTH, 1, {6'h00, `QSH_W_QUAD});
    lw = 4;
    chk("width", `QSH_W_QUAD, lane_width_o);
    mread(22'h2A00FE, 3, 9'h000);
    mwrite(`QSH_A_WIDTH, 1, {6'h00, `QSH_W_RSVD});
    mread(`QSH_A_WIDTH, 1, {3'h4, 4'h0, `QSH_W_QUAD});
    mwrite(22'h000500, 2, 8'h3C);
    drain(22'h000500, 2, 8'h3C);
    mwrite(`QSH_A_WIDTH, 1, {6'h00, `QSH_W_SINGLE});
    lw = 1;
    chk("width", `QSH_W_SINGLE, lane_width_o);
    give_verdict();
  end
endmodule // qsh_port_tb
